// >>> pkg/scgb_defs.svh
`ifndef SCGB_DEFS_SVH
`define SCGB_DEFS_SVH

// system control window base; the slave decodes the low offset bits only
`define SCGB_SYSCTL_BASE    32'h400f_e000
`define SCGB_OFS_W          12

// register byte offsets inside the window
`define SCGB_OFS_SLEEP_GATE 12'h114
`define SCGB_OFS_CTRL       12'h200
`define SCGB_OFS_STATUS     12'h204
`define SCGB_OFS_MASK       12'h208
`define SCGB_OFS_EFFECTIVE  12'h20c

// gate bit positions in the sleep gate word
`define SCGB_POS_COMPARATOR_TWO_GATE      26
`define SCGB_POS_COMPARATOR_ONE_GATE      25
`define SCGB_POS_COMPARATOR_ZERO_GATE      24
`define SCGB_POS_GPT2       18
`define SCGB_POS_GPT1       17
`define SCGB_POS_GPT0       16
`define SCGB_POS_TWI0       12
`define SCGB_POS_SYNC_SERIAL_ZERO_GATE       4
`define SCGB_POS_ASYNC_SERIAL_ONE_GATE      1
`define SCGB_POS_ASYNC_SERIAL_ZERO_GATE      0

// writable bits of the gate, status and mask words; all others read zero
`define SCGB_GATE_RW_MASK   32'h0707_1013
`define SCGB_CTRL_ACG_POS   0

// reset values
`define SCGB_GATE_RESET     32'h0000_0000
`define SCGB_CTRL_RESET     32'h0000_0000
`define SCGB_MASK_RESET     32'h0000_0000

// axi4-lite responses
`define SCGB_RESP_OKAY      2'h0
`define SCGB_RESP_SLVERR    2'h2

`endif

// >>> pkg/scgb_pkg.sv
`include "scgb_defs.svh"

package scgb_pkg;

  // one enable per gated unit, highest bit first
  typedef struct packed {
    logic comparator_two_gate;
    logic comparator_one_gate;
    logic comparator_zero_gate;
    logic gp_counter_two_gate;
    logic gp_counter_one_gate;
    logic gp_counter_zero_gate;
    logic two_wire_bus_zero_gate;
    logic sync_serial_zero_gate;
    logic async_serial_one_gate;
    logic async_serial_zero_gate;
  } scgb_units_t;

  // power mode, one-hot
  typedef enum logic [2:0] {
    PM_RUN   = 3'b001,
    PM_SLEEP = 3'b010,
    PM_DEEP  = 3'b100
  } scgb_pmode_t;

  // pick the unit bits out of a register-layout word
  function automatic scgb_units_t scgb_word_to_units(input logic [31:0] w);
    scgb_units_t u;
    u.comparator_two_gate    = w[`SCGB_POS_COMPARATOR_TWO_GATE];
    u.comparator_one_gate    = w[`SCGB_POS_COMPARATOR_ONE_GATE];
    u.comparator_zero_gate   = w[`SCGB_POS_COMPARATOR_ZERO_GATE];
    u.gp_counter_two_gate    = w[`SCGB_POS_GPT2];
    u.gp_counter_one_gate    = w[`SCGB_POS_GPT1];
    u.gp_counter_zero_gate   = w[`SCGB_POS_GPT0];
    u.two_wire_bus_zero_gate = w[`SCGB_POS_TWI0];
    u.sync_serial_zero_gate  = w[`SCGB_POS_SYNC_SERIAL_ZERO_GATE];
    u.async_serial_one_gate  = w[`SCGB_POS_ASYNC_SERIAL_ONE_GATE];
    u.async_serial_zero_gate = w[`SCGB_POS_ASYNC_SERIAL_ZERO_GATE];
    return u;
  endfunction : scgb_word_to_units

  // place unit bits back at their register positions, rest zero
  function automatic logic [31:0] scgb_units_to_word(input scgb_units_t u);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SCGB_POS_COMPARATOR_TWO_GATE] = u.comparator_two_gate;
    w[`SCGB_POS_COMPARATOR_ONE_GATE] = u.comparator_one_gate;
    w[`SCGB_POS_COMPARATOR_ZERO_GATE] = u.comparator_zero_gate;
    w[`SCGB_POS_GPT2]  = u.gp_counter_two_gate;
    w[`SCGB_POS_GPT1]  = u.gp_counter_one_gate;
    w[`SCGB_POS_GPT0]  = u.gp_counter_zero_gate;
    w[`SCGB_POS_TWI0]  = u.two_wire_bus_zero_gate;
    w[`SCGB_POS_SYNC_SERIAL_ZERO_GATE]  = u.sync_serial_zero_gate;
    w[`SCGB_POS_ASYNC_SERIAL_ONE_GATE] = u.async_serial_one_gate;
    w[`SCGB_POS_ASYNC_SERIAL_ZERO_GATE] = u.async_serial_zero_gate;
    return w;
  endfunction : scgb_units_to_word

  // byte-lane merge of write data into an old value
  function automatic logic [31:0] scgb_merge_strb(input logic [31:0] old_w,
                                                  input logic [31:0] new_w,
                                                  input logic [3:0]  strb);
    logic [31:0] w;
    w = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        w[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return w;
  endfunction : scgb_merge_strb

endpackage : scgb_pkg

// >>> sim/scgb_monitor.sv
`timescale 1ns/100ps

// port-level checker for the sleep gate bank; watches fault and bus timing
module scgb_monitor
  import scgb_pkg::*;
(
  input wire logic        aclk,           // system clock
  input wire logic        aresetn,        // synchronous reset, active low
  input wire logic        s_axi_awvalid,  // write address valid
  input wire logic        s_axi_awready,  // write address ready
  input wire logic        s_axi_wvalid,   // write data valid
  input wire logic        s_axi_wready,   // write data ready
  input wire logic [1:0]  s_axi_bresp,    // write response
  input wire logic        s_axi_bvalid,   // write response valid
  input wire logic        s_axi_bready,   // write response ready
  input wire logic        s_axi_arvalid,  // read address valid
  input wire logic        s_axi_arready,  // read address ready
  input wire logic [31:0] s_axi_rdata,    // read data
  input wire logic [1:0]  s_axi_rresp,    // read response
  input wire logic        s_axi_rvalid,   // read data valid
  input wire logic        s_axi_rready,   // read data ready
  input wire logic        sleep_req,      // sleep level
  input wire logic        deep_sleep_req, // deep sleep level
  input wire scgb_units_t run_gate_in,    // run-mode enables
  input wire scgb_units_t unit_access,    // access strobes
  input wire scgb_units_t unit_clk_en,    // clock enables
  input wire logic        bus_fault,      // fault pulse
  input wire scgb_units_t fault_units     // faulted units
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_gates_zero: assert property ($rose(aresetn) |-> unit_clk_en == '0)
    else $error("enables not cleared by reset");
  a_fault_on_gated: assert property ((unit_access & ~unit_clk_en) != '0
    |=> bus_fault && fault_units == $past(unit_access & ~unit_clk_en))
    else $error("missing fault for gated unit");
  a_no_false_fault: assert property ((unit_access & ~unit_clk_en) == '0 |=> !bus_fault)
    else $error("fault for clocked unit");
  a_fault_flags_tied: assert property (bus_fault == (fault_units != '0))
    else $error("fault pulse and unit flags disagree");
  // a waiting answer must hold still until it is taken
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_run_follows_in: assert property ((!sleep_req && !deep_sleep_req) ##1
    (!sleep_req && !deep_sleep_req) |=> unit_clk_en == $past(run_gate_in))
    else $error("run enables not applied");
endmodule : scgb_monitor

bind scgb_top scgb_monitor u_scgb_monitor (.*);

// >>> sim/test_sleep_mode_clock_gate_bank.sv
`timescale 1ns/100ps

`include "scgb_defs.svh"

// self-checking bench: drivers note results, one monitor compares them
module test_sleep_mode_clock_gate_bank
  import scgb_pkg::*;
;
  logic        aclk, aresetn;                                // clock, reset
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;                   // unused by slave
  logic [3:0]  s_axi_wstrb;                                  // byte strobes
  logic [1:0]  s_axi_bresp, s_axi_rresp;                     // responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sleep_req, deep_sleep_req;
  logic        bus_fault, irq;                               // fault pulse, interrupt
  scgb_units_t run_gate_in, deep_gate_in, unit_access, unit_clk_en, fault_units;
  int          error_cnt, total_checks;                      // verdict counters
  logic [31:0] lfsr_state = 32'h0000_8838;                   // fixed seed
  logic [33:0] rd_q[$];                                      // expected {rresp, rdata}
  logic [1:0]  wr_q[$];                                      // expected bresp
  scgb_units_t flt_q[$];                                     // expected fault units

  scgb_top u_scgb_top (.*);

  // free-running 40 MHz clock
  always #12.5 aclk = ~aclk;

  // shift register source of stimulus values
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
                  ^ lfsr_state[0]};
    return lfsr_state;
  endfunction : rnd

  // unit bits placed at their gate word positions
  function automatic logic [31:0] to_word(input logic [9:0] u);
    return {5'h00, u[9:7], 5'h00, u[6:4], 3'h0, u[3], 7'h00, u[2], 2'h0, u[1:0]};
  endfunction : to_word

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    wr_q.push_back(r);
    s_axi_awaddr <= `SCGB_SYSCTL_BASE + a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok |= s_axi_awvalid && s_axi_awready;
      w_ok |= s_axi_wvalid && s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  // read: rready held until the answer is seen
  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    rd_q.push_back(exp);
    s_axi_araddr <= `SCGB_SYSCTL_BASE + a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // result monitor: oldest note against each answer as it appears
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check(s_axi_bresp, wr_q.pop_front());
    if (bus_fault)
      check(fault_units, flt_q.pop_front());
  end

  // watchdog sized well past the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] w, r;
    scgb_units_t ug, st, ex, ru, de;
    {aclk, aresetn, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, sleep_req, deep_sleep_req} = '0;
    {deep_gate_in, unit_access} = '0;
    run_gate_in = '1;                // run enables high through reset, so the clear shows
    s_axi_wstrb = 4'hf;
    st = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    run_gate_in <= '0;
    repeat (2) @(posedge aclk);
    check(unit_clk_en, 10'h000);
    rd(`SCGB_OFS_SLEEP_GATE, 34'h0);
    rd(`SCGB_OFS_CTRL, 34'h0);
    rd(`SCGB_OFS_MASK, 34'h0);
    // unmapped neighbour is refused and leaves the gate word alone
    rd(12'h118, {`SCGB_RESP_SLVERR, 32'h0000_0000});
    wr(12'h118, 32'hffff_ffff, `SCGB_RESP_SLVERR);
    rd(`SCGB_OFS_SLEEP_GATE, 34'h0);
    wr(`SCGB_OFS_SLEEP_GATE, 32'hffff_ffff, `SCGB_RESP_OKAY);
    rd(`SCGB_OFS_SLEEP_GATE, {2'h0, `SCGB_GATE_RW_MASK});
    repeat (6)
    begin
      w = rnd();
      wr(`SCGB_OFS_SLEEP_GATE, w, `SCGB_RESP_OKAY);
      rd(`SCGB_OFS_SLEEP_GATE, {2'h0, w & `SCGB_GATE_RW_MASK});
    end
    // read-modify-write of the last value read back, reserved zeros kept
    wr(`SCGB_OFS_SLEEP_GATE, (w & `SCGB_GATE_RW_MASK) | 32'h0000_0010, `SCGB_RESP_OKAY);
    rd(`SCGB_OFS_SLEEP_GATE, {2'h0, (w & `SCGB_GATE_RW_MASK) | 32'h0000_0010});
    // byte lane 0 only: upper lanes keep their old gate bits
    s_axi_wstrb <= 4'h1;
    wr(`SCGB_OFS_SLEEP_GATE, 32'hffff_ffff, `SCGB_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`SCGB_OFS_SLEEP_GATE, {2'h0, (w & 32'h0707_1000) | 32'h0000_0013});
    // each gate bit alone, in sleep with automatic gating on
    wr(`SCGB_OFS_CTRL, 32'h1, `SCGB_RESP_OKAY);
    sleep_req <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      wr(`SCGB_OFS_SLEEP_GATE, to_word(10'h001 << i), `SCGB_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(unit_clk_en, 10'h001 << i);
      rd(`SCGB_OFS_EFFECTIVE, {2'h0, to_word(10'h001 << i)});
    end
    // mode and automatic gating select choose the enable source
    repeat (12)
    begin
      r = rnd();
      w = rnd();
      ug = w[9:0];
      w = rnd();
      ru = w[9:0];
      de = w[25:16];
      wr(`SCGB_OFS_CTRL, {31'h0, r[0]}, `SCGB_RESP_OKAY);
      wr(`SCGB_OFS_SLEEP_GATE, to_word(ug), `SCGB_RESP_OKAY);
      run_gate_in <= ru;
      deep_gate_in <= de;
      sleep_req <= r[1];
      deep_sleep_req <= r[2];
      ex = !r[0] ? ru : r[2] ? de : r[1] ? ug : ru;
      repeat (4) @(posedge aclk);
      check(unit_clk_en, ex);
    end
    // faults on gated units, then status, mask and clear
    wr(`SCGB_OFS_CTRL, 32'h1, `SCGB_RESP_OKAY);
    sleep_req <= 1'b1;
    deep_sleep_req <= 1'b0;
    w = rnd();
    ug = w[9:0] & 10'h2aa;
    wr(`SCGB_OFS_SLEEP_GATE, to_word(ug), `SCGB_RESP_OKAY);
    wr(`SCGB_OFS_MASK, to_word(10'h3ff), `SCGB_RESP_OKAY);
    repeat (4) @(posedge aclk);
    repeat (8)
    begin
      w = rnd();
      unit_access <= w[9:0];
      if ((w[9:0] & ~ug) != 10'h000)
        flt_q.push_back(w[9:0] & ~ug);
      st |= w[9:0] & ~ug;
      @(posedge aclk);
      unit_access <= '0;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
    rd(`SCGB_OFS_STATUS, {2'h0, to_word(st)});
    check(irq, st != 10'h000);
    wr(`SCGB_OFS_STATUS, to_word(st), `SCGB_RESP_OKAY);
    wr(`SCGB_OFS_MASK, 32'h0, `SCGB_RESP_OKAY);
    flt_q.push_back(10'h001);
    unit_access <= 10'h001;
    @(posedge aclk);
    unit_access <= '0;
    repeat (4) @(posedge aclk);
    check(irq, 1'b0);
    wr(`SCGB_OFS_MASK, 32'h1, `SCGB_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(irq, 1'b1);
    wr(`SCGB_OFS_STATUS, 32'h1, `SCGB_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    rd(`SCGB_OFS_STATUS, 34'h0);
    // let the monitor take the last answer, then every note must be used up
    @(posedge aclk);
    check(flt_q.size() + rd_q.size() + wr_q.size(), 0);
    print_verdict();
  end
endmodule : test_sleep_mode_clock_gate_bank

// >>> src/scgb_top.sv
// Function
// R1: gate bit one clocks unit, zero disables
// R2: access to unclocked unit answers bus fault
// R3: all gate bits reset to zero
// R4: sleep register applies only during sleep
// R5: sleep values need auto gating select set
// R6: bits 26..24 gate comparators 2..0
// R7: bits 18..16 gate counters 2..0
// R8: bit 12 gates two-wire bus unit
// R9: bit 4 gates synchronous serial unit
// R10: bits 1..0 gate async serial 1..0
// R11: reserved bits read zero, ignore writes
// R12: software preserves reserved bits on update
// R13: software enables every unit it needs
// R14: register sits at offset 0x114
// R15: gate change reaches enable next cycle
`timescale 1ns/100ps

`include "scgb_defs.svh"

module scgb_top
  import scgb_pkg::*;
(
  input  wire logic        aclk,            // system clock, 40 MHz
  input  wire logic        aresetn,         // synchronous reset, active low
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,    // write address
  input  wire logic [2:0]  s_axi_awprot,    // write protection, unused
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [31:0] s_axi_araddr,    // read address
  input  wire logic [2:0]  s_axi_arprot,    // read protection, unused
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  // power controller and sibling gate registers, same clock
  input  wire logic        sleep_req,       // core is in sleep
  input  wire logic        deep_sleep_req,  // core is in deep sleep
  input  wire scgb_units_t run_gate_in,     // run-mode enables
  input  wire scgb_units_t deep_gate_in,    // deep-sleep enables
  // peripheral bus side
  input  wire scgb_units_t unit_access,     // per-unit access strobe
  output scgb_units_t      unit_clk_en,     // clock enable per unit
  output logic             bus_fault,       // one-cycle fault pulse
  output scgb_units_t      fault_units,     // units that faulted
  output logic             irq              // level interrupt
);

  localparam int OW = `SCGB_OFS_W;

  // registers
  logic [31:0]  sleep_gate_reg;             // sleep_clock_gate_one
  logic         acg_reg;                    // auto_clock_gating_select
  scgb_units_t  status_reg;                 // sticky fault flags
  scgb_units_t  mask_reg;                   // interrupt mask
  scgb_pmode_t  pmode_reg;                  // current power mode
  scgb_units_t  gate_next;                  // enables for the next cycle

  // write channel holding state
  logic [OW-1:0] aw_addr_reg;               // captured write offset
  logic          aw_held_reg;               // write address captured
  logic [31:0]   w_data_reg;                // captured write data
  logic [3:0]    w_strb_reg;                // captured strobes
  logic          w_held_reg;                // write data captured
  logic          wr_fire;                   // both halves present
  logic          wr_hit;                    // write hits a mapped offset

  // read channel
  logic          rd_fire;                   // read address handshake
  logic [31:0]   rd_word;                   // decoded read value
  logic          rd_hit;                    // read hits a mapped offset

  // fault feedback from the gate unit
  scgb_units_t   fault_units_w;             // faulting units this cycle
  logic          fault_pulse_w;             // any fault this cycle

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // power mode tracker; deep sleep outranks sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pmode_reg <= PM_RUN;
    end
    else if (deep_sleep_req)
    begin
      pmode_reg <= PM_DEEP;
    end
    else if (sleep_req)
    begin
      pmode_reg <= PM_SLEEP;
    end
    else
    begin
      pmode_reg <= PM_RUN;
    end
  end

  // enable selection: without auto gating the run enables stay in force
  // through every mode, so the sleep word only matters once software opts in
  always_comb
  begin
    gate_next = run_gate_in;
    if (acg_reg)                                        // R5
    begin
      unique case (pmode_reg)
        PM_RUN:   gate_next = run_gate_in;
        PM_SLEEP: gate_next = scgb_word_to_units(sleep_gate_reg); // R4 R6 R7 R8 R9 R10
        PM_DEEP:  gate_next = deep_gate_in;
        default:  gate_next = run_gate_in;      // illegal mode code: fall back to run enables
      endcase
    end
  end

  // per-unit enable and fault checking
  scgb_unit_gate u_gate (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .gate_want   (gate_next),
    .unit_access (unit_access),
    .unit_clk_en (unit_clk_en),
    .fault_pulse (fault_pulse_w),
    .fault_units (fault_units_w)
  );

  assign bus_fault   = fault_pulse_w;
  assign fault_units = fault_units_w;

  // write address channel: ready while nothing is held or answered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr[OW-1:0];
    end
    else if (wr_fire)
    begin
      aw_held_reg <= 1'b0;                  // consumed by the write
    end
    else if (!aw_held_reg && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, independent of the address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_held_reg <= 1'b0;
    end
    else if (!w_held_reg && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // write decode; unmapped offsets get slverr and change nothing
  always_comb
  begin
    unique case (aw_addr_reg)
      `SCGB_OFS_SLEEP_GATE, `SCGB_OFS_CTRL,
      `SCGB_OFS_STATUS, `SCGB_OFS_MASK,
      `SCGB_OFS_EFFECTIVE: wr_hit = 1'b1;   // R14
      default:             wr_hit = 1'b0;
    endcase
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCGB_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `SCGB_RESP_OKAY : `SCGB_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // sleep gate word: only the documented bits can ever hold a one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_gate_reg <= `SCGB_GATE_RESET;   // R3
    end
    else if (wr_fire && aw_addr_reg == `SCGB_OFS_SLEEP_GATE)  // R14
    begin
      sleep_gate_reg <= scgb_merge_strb(sleep_gate_reg, w_data_reg,
                                        w_strb_reg) & `SCGB_GATE_RW_MASK; // R11
    end
  end

  // control word: auto gating select lives in bit 0, byte lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acg_reg <= 1'(`SCGB_CTRL_RESET);
    end
    else if (wr_fire && aw_addr_reg == `SCGB_OFS_CTRL && w_strb_reg[0])
    begin
      acg_reg <= w_data_reg[`SCGB_CTRL_ACG_POS];   // R5
    end
  end

  // interrupt mask, same layout as the gate word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_reg <= scgb_word_to_units(`SCGB_MASK_RESET);
    end
    else if (wr_fire && aw_addr_reg == `SCGB_OFS_MASK)
    begin
      mask_reg <= scgb_word_to_units(scgb_merge_strb(scgb_units_to_word(mask_reg),
                                                     w_data_reg, w_strb_reg));
    end
  end

  // sticky fault flags; write one clears, a fault in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg <= '0;
    end
    else if (wr_fire && aw_addr_reg == `SCGB_OFS_STATUS)
    begin
      status_reg <= (status_reg & ~scgb_word_to_units(
                       scgb_merge_strb(32'h0000_0000, w_data_reg, w_strb_reg)))
                    | fault_units_w;
    end
    else
    begin
      status_reg <= status_reg | fault_units_w;
    end
  end

  // interrupt level: registered, so it lags a new flag by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // read decode; reserved bits come back as zero
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr[OW-1:0])
      `SCGB_OFS_SLEEP_GATE: rd_word = sleep_gate_reg & `SCGB_GATE_RW_MASK; // R11 R14
      `SCGB_OFS_CTRL:       rd_word = {31'h0000_0000, acg_reg};
      `SCGB_OFS_STATUS:     rd_word = scgb_units_to_word(status_reg);
      `SCGB_OFS_MASK:       rd_word = scgb_units_to_word(mask_reg);
      `SCGB_OFS_EFFECTIVE:  rd_word = scgb_units_to_word(unit_clk_en);
      default:              rd_hit  = 1'b0;
    endcase
  end

  // read channel: one outstanding read, data one cycle after the handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SCGB_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `SCGB_RESP_OKAY : `SCGB_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : scgb_top

// >>> src/scgb_unit_gate.sv
`timescale 1ns/100ps

module scgb_unit_gate
  import scgb_pkg::*;
(
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // synchronous reset, active low
  input  wire scgb_units_t gate_want,     // enables chosen by the mode logic
  input  wire scgb_units_t unit_access,   // per-unit access strobe this cycle
  output scgb_units_t      unit_clk_en,   // registered clock enables
  output logic             fault_pulse,   // one-cycle bus fault answer
  output scgb_units_t      fault_units    // which units faulted, one cycle
);

  // enables are registered so the external gating cell only ever sees a
  // level that changed just after a rising edge: no glitch on the low phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_clk_en <= '0;                  // R3
    end
    else
    begin
      unit_clk_en <= gate_want;           // R1 R15
    end
  end

  // an access to a unit whose clock is off is answered with a fault;
  // checked against the enable the unit really has right now
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_pulse <= 1'b0;
      fault_units <= '0;
    end
    else
    begin
      fault_units <= unit_access & ~unit_clk_en;       // R2
      fault_pulse <= |(unit_access & ~unit_clk_en);    // R2
    end
  end

endmodule : scgb_unit_gate
